// ### shared/osd_pkg.sv
// constants and encodings shared by the oscillator select and clock divider block
package osd_pkg;
    // register bus geometry
    localparam int DW = 16;
    localparam int AW = 4;
    // register offsets on the plain register port
    localparam logic [3:0] OFF_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFF_CLK_DIV = 4'h2;
    localparam logic [3:0] OFF_UNLOCK = 4'h4;
    // oscillator control field positions
    localparam int OC_CUR_LSB = 12;
    localparam int OC_REQ_LSB = 8;
    localparam int OC_FREEZE = 7;
    localparam int OC_LOCK = 5;
    localparam int OC_FAIL = 3;
    localparam int OC_SEC_EN = 1;
    localparam int OC_SWITCH = 0;
    // clock divisor field positions
    localparam int CD_ROI = 15;
    localparam int CD_DOZE_LSB = 12;
    localparam int CD_DOZE_EN = 11;
    localparam int CD_FRC_LSB = 8;
    localparam int CD_POST_LSB = 6;
    localparam int CD_PRE_LSB = 0;
    // clock divisor reset values
    localparam logic [2:0] DOZE_RST = 3'h3;
    localparam logic [2:0] FRC_RST = 3'h0;
    localparam logic [1:0] POST_RST = 2'h1;
    localparam logic [4:0] PRE_RST = 5'h00;
    // source encodings, shared by current and requested selection
    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] SRC_SECONDARY = 3'h4;
    localparam logic [2:0] SRC_SLOW_RC = 3'h5;
    localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FAST_RC_DIVN = 3'h7;
    // primary submodes
    localparam logic [1:0] PRI_HIGH_SPEED = 2'h2;
    localparam logic [1:0] PRI_STANDARD = 2'h1;
    localparam logic [1:0] PRI_EXTERNAL = 2'h0;
    // output divider codes; code 2 is reserved
    localparam logic [1:0] POST_DIV2 = 2'h0;
    localparam logic [1:0] POST_DIV4 = 2'h1;
    localparam logic [1:0] POST_RESERVED = 2'h2;
    localparam logic [1:0] POST_DIV8 = 2'h3;
    // prescaler offset: ratio is field plus two
    localparam logic [5:0] PRE_OFFSET = 6'h02;
    // fast rc code that divides by 256 instead of a power up to 64
    localparam logic [2:0] FRC_CODE_256 = 3'h7;
    // unlock keys, pairs of back to back writes to the unlock offset
    localparam logic [15:0] KEY_HI_A = 16'h00c3;
    localparam logic [15:0] KEY_HI_B = 16'h003c;
    localparam logic [15:0] KEY_LO_A = 16'h0096;
    localparam logic [15:0] KEY_LO_B = 16'h0069;
    // new-source clock periods to wait before the switch takes effect
    localparam logic [3:0] SETTLE_TICKS = 4'ha;
    // switch sequencer and unlock tracker states
    typedef enum logic [1:0] {ST_POR, ST_IDLE, ST_WAIT_SRC, ST_SETTLE} osd_sw_state_t;
    typedef enum logic [2:0] {
        UL_NONE, UL_HI_KEY1, UL_LO_KEY1, UL_HI_OPEN, UL_LO_OPEN
    } osd_unlock_t;
endpackage

// ### hdl/osd_clock_ctrl.sv
// oscillator selection, switch sequencing and clock divisor registers
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module osd_clock_ctrl (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // register port
    input wire logic [osd_pkg::AW-1:0] ADDR,
    input wire logic [osd_pkg::DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [osd_pkg::DW-1:0] RDATA,
    // nonvolatile configuration, static after power-on
    input wire logic [2:0] INIT_SOURCE_CONFIG,
    input wire logic [1:0] PRIMARY_SUBMODE_CONFIG,
    input wire logic SWITCH_CONFIG_BIT0,
    // clock-source side
    input wire logic PLL_LOCK,
    input wire logic CLOCK_FAIL,
    input wire logic NEW_SOURCE_READY,
    input wire logic NEW_SOURCE_TICK,
    input wire logic OSC_TICK,
    input wire logic INTERRUPT,
    output logic [2:0] CURRENT_SOURCE,
    output logic [2:0] REQUESTED_SOURCE,
    output logic SWITCH_BUSY,
    output logic [1:0] PRIMARY_MODE,
    output logic PRIMARY_ACTIVE,
    output logic SECONDARY_ENABLE,
    output logic PLL_ENABLE,
    output logic [5:0] PLL_PRE_RATIO,
    output logic [3:0] PLL_POST_RATIO,
    output logic [8:0] FRC_DIV_RATIO,
    output logic INSTR_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic CPU_CLK_EN
);
    // every flip-flop of the block lives in this one record
    typedef struct packed {
        osd_pkg::osd_sw_state_t sw_st; // switch sequencer
        osd_pkg::osd_unlock_t ul_st; // unlock tracker
        logic [2:0] cur_src; // source in use
        logic [2:0] req_src; // requested source
        logic [1:0] pri_mode; // primary submode, caught at power-on
        logic freeze; // configuration freeze enable
        logic fail; // clock fail flag
        logic sec_en; // secondary crystal enable
        logic sw_req; // switch request
        logic recover_on_interrupt; // recover on interrupt
        logic [2:0] doze; // reduction ratio
        logic doze_en; // reduction enable
        logic [2:0] frc_div; // fast rc postscaler
        logic [1:0] post; // pll output divider
        logic [4:0] pre; // pll input prescaler
        logic [3:0] settle_cnt; // new-source ticks seen
        logic [15:0] rdata; // read data, one cycle after the strobe
        logic half; // oscillator tick halver
        logic [6:0] doze_cnt; // instruction ticks for the reduction
        logic fcy_en; // instruction clock enable
        logic cpu_en; // processor clock enable
    } osd_state_t;

    osd_state_t s_q; // registered state
    osd_state_t s_d; // next state
    logic locked; // freeze in force
    logic pll_on; // pll needed now
    logic lock_bit; // lock status as read

    // a pll source needs the multiplier running
    function automatic logic is_pll(input logic [2:0] src);
        is_pll = (src == osd_pkg::SRC_FAST_RC_PLL) || (src == osd_pkg::SRC_PRIMARY_PLL);
    endfunction

    // primary sources use the submode field
    function automatic logic is_primary(input logic [2:0] src);
        is_primary = (src == osd_pkg::SRC_PRIMARY) || (src == osd_pkg::SRC_PRIMARY_PLL);
    endfunction

    // low bits of the reduction counter that must be zero for a tick
    function automatic logic [6:0] doze_mask(input logic [2:0] code);
        doze_mask = 7'((8'h01 << code) - 8'h01);
    endfunction

    // assemble the oscillator control word, unimplemented bits zero
    function automatic logic [15:0] osc_word(input osd_state_t s, input logic lk);
        osc_word = 16'h0000;
        osc_word[osd_pkg::OC_CUR_LSB +: 3] = s.cur_src;
        osc_word[osd_pkg::OC_REQ_LSB +: 3] = s.req_src;
        osc_word[osd_pkg::OC_FREEZE] = s.freeze;
        osc_word[osd_pkg::OC_LOCK] = lk;
        osc_word[osd_pkg::OC_FAIL] = s.fail;
        osc_word[osd_pkg::OC_SEC_EN] = s.sec_en;
        osc_word[osd_pkg::OC_SWITCH] = s.sw_req;
    endfunction

    // assemble the clock divisor word, bit 5 stays zero
    function automatic logic [15:0] div_word(input osd_state_t s);
        div_word = 16'h0000;
        div_word[osd_pkg::CD_ROI] = s.recover_on_interrupt;
        div_word[osd_pkg::CD_DOZE_LSB +: 3] = s.doze;
        div_word[osd_pkg::CD_DOZE_EN] = s.doze_en;
        div_word[osd_pkg::CD_FRC_LSB +: 3] = s.frc_div;
        div_word[osd_pkg::CD_POST_LSB +: 2] = s.post;
        div_word[osd_pkg::CD_PRE_LSB +: 5] = s.pre;
    endfunction

    // freeze only bites when the configuration bit allows it
    assign locked = s_q.freeze && SWITCH_CONFIG_BIT0;
    // pll runs for a pll source in use or one being switched to
    assign pll_on = is_pll(s_q.cur_src)
        || ((s_q.sw_st != osd_pkg::ST_IDLE) && is_pll(s_q.req_src));
    // lock never reports while the pll is off
    assign lock_bit = pll_on && PLL_LOCK;

    // next-state logic for the whole block
    always_comb begin
        logic wr_osc;
        logic wr_div;
        logic wr_key;
        wr_osc = WR && (ADDR == osd_pkg::OFF_OSC_CTRL);
        wr_div = WR && (ADDR == osd_pkg::OFF_CLK_DIV);
        wr_key = WR && (ADDR == osd_pkg::OFF_UNLOCK);
        s_d = s_q;

        // unlock tracker: keys must arrive back to back
        if (WR) begin
            s_d.ul_st = osd_pkg::UL_NONE;
            if (wr_key) begin
                case (s_q.ul_st)
                    osd_pkg::UL_HI_KEY1: begin
                        if (WDATA == osd_pkg::KEY_HI_B) begin
                            s_d.ul_st = osd_pkg::UL_HI_OPEN;
                        end
                    end
                    osd_pkg::UL_LO_KEY1: begin
                        if (WDATA == osd_pkg::KEY_LO_B) begin
                            s_d.ul_st = osd_pkg::UL_LO_OPEN;
                        end
                    end
                    default: begin
                        if (WDATA == osd_pkg::KEY_HI_A) begin
                            s_d.ul_st = osd_pkg::UL_HI_KEY1;
                        end else if (WDATA == osd_pkg::KEY_LO_A) begin
                            s_d.ul_st = osd_pkg::UL_LO_KEY1;
                        end
                    end
                endcase
            end
        end

        // high byte: requested source, only once opened and not frozen
        if (wr_osc && (s_q.ul_st == osd_pkg::UL_HI_OPEN) && !locked
                && (s_q.sw_st == osd_pkg::ST_IDLE)) begin
            s_d.req_src = WDATA[osd_pkg::OC_REQ_LSB +: 3];
        end

        // low byte: freeze, fail clear, secondary enable, switch request
        if (wr_osc && (s_q.ul_st == osd_pkg::UL_LO_OPEN)) begin
            // freeze can be set at any time but not dropped while in force
            s_d.freeze = locked ? 1'b1 : WDATA[osd_pkg::OC_FREEZE];
            s_d.sec_en = WDATA[osd_pkg::OC_SEC_EN];
            if (!WDATA[osd_pkg::OC_FAIL]) begin
                s_d.fail = 1'b0;
            end
            if (WDATA[osd_pkg::OC_SWITCH] && !locked) begin
                s_d.sw_req = 1'b1;
            end
        end

        // clock divisor: pll and postscaler fields freeze with the lock
        if (wr_div) begin
            s_d.recover_on_interrupt = WDATA[osd_pkg::CD_ROI];
            s_d.doze = WDATA[osd_pkg::CD_DOZE_LSB +: 3];
            s_d.doze_en = WDATA[osd_pkg::CD_DOZE_EN];
            if (!locked) begin
                s_d.frc_div = WDATA[osd_pkg::CD_FRC_LSB +: 3];
                s_d.pre = WDATA[osd_pkg::CD_PRE_LSB +: 5];
                // a reserved divider code keeps the previous setting
                if (WDATA[osd_pkg::CD_POST_LSB +: 2] != osd_pkg::POST_RESERVED) begin
                    s_d.post = WDATA[osd_pkg::CD_POST_LSB +: 2];
                end
            end
        end

        // interrupt recovery outranks a software write in the same cycle
        if (INTERRUPT && s_q.recover_on_interrupt) begin
            s_d.doze_en = 1'b0;
        end

        // switch sequencer
        case (s_q.sw_st)
            osd_pkg::ST_POR: begin
                // erased fuses read all ones, which selects fast rc divide-n
                s_d.cur_src = INIT_SOURCE_CONFIG;
                s_d.req_src = INIT_SOURCE_CONFIG;
                s_d.pri_mode = PRIMARY_SUBMODE_CONFIG;
                s_d.sw_st = osd_pkg::ST_IDLE;
            end
            osd_pkg::ST_IDLE: begin
                if (s_q.sw_req) begin
                    if (s_q.req_src == s_q.cur_src) begin
                        s_d.sw_req = 1'b0;
                    end else begin
                        // a valid switch starts with a clean fail flag
                        s_d.fail = 1'b0;
                        s_d.sw_st = osd_pkg::ST_WAIT_SRC;
                    end
                end
            end
            osd_pkg::ST_WAIT_SRC: begin
                if (NEW_SOURCE_READY && (!is_pll(s_q.req_src) || PLL_LOCK)) begin
                    s_d.settle_cnt = 4'h0;
                    s_d.sw_st = osd_pkg::ST_SETTLE;
                end
            end
            osd_pkg::ST_SETTLE: begin
                if (NEW_SOURCE_TICK) begin
                    s_d.settle_cnt = s_q.settle_cnt + 4'h1;
                    if (s_q.settle_cnt == osd_pkg::SETTLE_TICKS - 4'h1) begin
                        s_d.cur_src = s_q.req_src;
                        s_d.sw_req = 1'b0;
                        s_d.sw_st = osd_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                s_d.sw_st = osd_pkg::ST_IDLE;
            end
        endcase

        // monitor event wins over any clear in the same cycle
        if (CLOCK_FAIL) begin
            s_d.fail = 1'b1;
        end

        // instruction clock: every second tick of the chosen source
        s_d.fcy_en = 1'b0;
        s_d.cpu_en = 1'b0;
        if (OSC_TICK) begin
            s_d.half = !s_q.half;
            if (s_q.half) begin
                s_d.fcy_en = 1'b1;
                s_d.doze_cnt = s_q.doze_cnt + 7'h01;
                // reduced processor ticks only when enabled, else every tick
                if (!s_q.doze_en || ((s_q.doze_cnt & doze_mask(s_q.doze)) == 7'h00)) begin
                    s_d.cpu_en = 1'b1;
                end
            end
        end

        // read data stands only in the cycle after the strobe
        s_d.rdata = 16'h0000;
        if (RD) begin
            if (ADDR == osd_pkg::OFF_OSC_CTRL) begin
                s_d.rdata = osc_word(s_q, lock_bit);
            end else if (ADDR == osd_pkg::OFF_CLK_DIV) begin
                s_d.rdata = div_word(s_q);
            end
        end
    end

    // state register; reset values are constants only
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.sw_st <= osd_pkg::ST_POR;
            s_q.ul_st <= osd_pkg::UL_NONE;
            s_q.doze <= osd_pkg::DOZE_RST;
            s_q.frc_div <= osd_pkg::FRC_RST;
            s_q.post <= osd_pkg::POST_RST;
            s_q.pre <= osd_pkg::PRE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ratio outputs for the pll and fast rc dividers
    always_comb begin
        PLL_PRE_RATIO = {1'b0, s_q.pre} + osd_pkg::PRE_OFFSET;
        case (s_q.post)
            osd_pkg::POST_DIV2: PLL_POST_RATIO = 4'h2;
            osd_pkg::POST_DIV8: PLL_POST_RATIO = 4'h8;
            default: PLL_POST_RATIO = 4'h4;
        endcase
        if (s_q.frc_div == osd_pkg::FRC_CODE_256) begin
            FRC_DIV_RATIO = 9'h100;
        end else begin
            FRC_DIV_RATIO = 9'(10'h001 << s_q.frc_div);
        end
    end

    // outputs from the state record; busy, primary mode and pll enable are decoded from it
    assign RDATA = s_q.rdata;
    assign CURRENT_SOURCE = s_q.cur_src;
    assign REQUESTED_SOURCE = s_q.req_src;
    assign SWITCH_BUSY = (s_q.sw_st == osd_pkg::ST_WAIT_SRC)
        || (s_q.sw_st == osd_pkg::ST_SETTLE);
    assign PRIMARY_ACTIVE = is_primary(s_q.cur_src);
    assign PRIMARY_MODE = PRIMARY_ACTIVE ? s_q.pri_mode : osd_pkg::PRI_EXTERNAL;
    assign SECONDARY_ENABLE = s_q.sec_en;
    assign PLL_ENABLE = pll_on;
    assign INSTR_CLK_EN = s_q.fcy_en;
    assign PERIPH_CLK_EN = s_q.fcy_en;
    assign CPU_CLK_EN = s_q.cpu_en;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    // switch request seen against the source already in use
    sequence seq_redundant;
        (s_q.sw_st == osd_pkg::ST_IDLE) && s_q.sw_req && (s_q.req_src == s_q.cur_src);
    endsequence
    // final new-source tick of the settling wait
    sequence seq_last_tick;
        (s_q.sw_st == osd_pkg::ST_SETTLE) && NEW_SOURCE_TICK
            && (s_q.settle_cnt == osd_pkg::SETTLE_TICKS - 4'h1);
    endsequence

    a_redundant_abort: assert property (seq_redundant
            |=> !s_q.sw_req && $stable(s_q.cur_src))
        else $error("redundant switch not aborted");
    a_switch_done: assert property (seq_last_tick |=> !s_q.sw_req
            && (s_q.cur_src == $past(s_q.req_src)) && (s_q.sw_st == osd_pkg::ST_IDLE))
        else $error("switch did not complete on last settle tick");
    a_settle_hold: assert property ((s_q.sw_st == osd_pkg::ST_SETTLE) && !NEW_SOURCE_TICK
            |=> $stable(s_q.cur_src))
        else $error("source changed before settling ended");
    a_por_load: assert property ((s_q.sw_st == osd_pkg::ST_POR)
            |=> (s_q.cur_src == $past(INIT_SOURCE_CONFIG))
            && (s_q.req_src == s_q.cur_src))
        else $error("power-on source not loaded");
    a_lock_off: assert property (!pll_on && RD && (ADDR == osd_pkg::OFF_OSC_CTRL)
            |=> !RDATA[osd_pkg::OC_LOCK])
        else $error("lock read high with pll off");
    a_fail_set: assert property (CLOCK_FAIL |=> s_q.fail)
        else $error("clock fail event lost");
    a_roi_clear: assert property (INTERRUPT && s_q.recover_on_interrupt |=> !s_q.doze_en)
        else $error("interrupt did not clear reduction enable");
    // any write while frozen, divisor writes too, leaves clock and pll fields alone
    a_frozen_req: assert property (locked && WR |=> $stable(s_q.req_src)
            && $stable(s_q.frc_div) && $stable(s_q.post) && $stable(s_q.pre))
        else $error("frozen settings changed");
    a_no_unlock: assert property (WR && (ADDR == osd_pkg::OFF_OSC_CTRL)
            && (s_q.ul_st == osd_pkg::UL_NONE)
            |=> $stable(s_q.sec_en) && $stable(s_q.req_src))
        else $error("locked register accepted a write");
    a_one_write: assert property (WR |=> ((s_q.ul_st != osd_pkg::UL_HI_OPEN)
            && (s_q.ul_st != osd_pkg::UL_LO_OPEN)) || ($past(ADDR) == osd_pkg::OFF_UNLOCK))
        else $error("unlock survived a write");
    a_zero_bits: assert property (RD |=> (RDATA[15] == 1'b0)
            || ($past(ADDR) != osd_pkg::OFF_OSC_CTRL))
        else $error("unimplemented bit read nonzero");
    a_cpu_full: assert property (!s_q.doze_en && OSC_TICK && s_q.half
            |=> CPU_CLK_EN && INSTR_CLK_EN)
        else $error("processor tick missing at full ratio");
endmodule

// ### verif/tb_oscillator_select_and_clock_divider.sv
// self-checking bench for the oscillator select and clock divider block
`timescale 1ns/1ps
module tb_oscillator_select_and_clock_divider;
    // stimulus side, all given a value at time zero
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0;
    logic [2:0] init_cfg = 3'h7;
    logic [1:0] sub_cfg = 2'h0;
    logic cfg0 = 1'b0, pll_lock = 1'b1, clk_fail = 1'b0, src_rdy = 1'b0;
    logic src_tick = 1'b0, osc_tick = 1'b0, irq = 1'b0;
    // observed outputs
    logic [15:0] rdata;
    logic [2:0] cur_src, req_src;
    logic [1:0] pri_mode;
    logic busy, pri_act, sec_en, pll_en, instr_en, periph_en, cpu_en;
    logic [5:0] pre_ratio;
    logic [3:0] post_ratio;
    logic [8:0] frc_ratio;
    // score and enable-pulse tallies
    int fails = 0, check_count = 0;
    int n_instr = 0, n_cpu = 0, n_per = 0, i0 = 0, c0 = 0, p0 = 0;

    osd_clock_ctrl i_dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .INIT_SOURCE_CONFIG(init_cfg), .PRIMARY_SUBMODE_CONFIG(sub_cfg),
        .SWITCH_CONFIG_BIT0(cfg0), .PLL_LOCK(pll_lock), .CLOCK_FAIL(clk_fail),
        .NEW_SOURCE_READY(src_rdy), .NEW_SOURCE_TICK(src_tick), .OSC_TICK(osc_tick),
        .INTERRUPT(irq), .CURRENT_SOURCE(cur_src), .REQUESTED_SOURCE(req_src),
        .SWITCH_BUSY(busy), .PRIMARY_MODE(pri_mode), .PRIMARY_ACTIVE(pri_act),
        .SECONDARY_ENABLE(sec_en), .PLL_ENABLE(pll_en), .PLL_PRE_RATIO(pre_ratio),
        .PLL_POST_RATIO(post_ratio), .FRC_DIV_RATIO(frc_ratio), .INSTR_CLK_EN(instr_en),
        .PERIPH_CLK_EN(periph_en), .CPU_CLK_EN(cpu_en)
    );

    // 200 mhz system clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // tally enable pulses; unknowns are not counted
    always @(posedge clk_sys) begin
        if (instr_en === 1'b1) n_instr++;
        if (cpu_en === 1'b1) n_cpu++;
        if (periph_en === 1'b1) n_per++;
    end

    // verdict and end of run, shared with the watchdog
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // compare with case inequality so unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one-cycle write, then an idle cycle so strobes never toggle twice a step
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge clk_sys);
    endtask

    // key pair then the guarded write; hi opens requested source, lo the rest
    task automatic osc_wr(input bit hi, input logic [15:0] d);
        wr_reg(4'h4, hi ? 16'h00c3 : 16'h0096);
        wr_reg(4'h4, hi ? 16'h003c : 16'h0069);
        wr_reg(4'h0, d);
    endtask

    // n pulses on one input: 0 new-source tick, 1 osc tick, 2 clock fail, 3 interrupt
    task automatic strobe(input int n, input int sel);
        repeat (n) begin
            src_tick <= (sel == 0);
            osc_tick <= (sel == 1);
            clk_fail <= (sel == 2);
            irq <= (sel == 3);
            @(posedge clk_sys);
            {src_tick, osc_tick, clk_fail, irq} <= 4'h0;
            @(posedge clk_sys);
        end
    endtask

    // reset for 3 cycles; current source reads zero while held
    task automatic do_reset(input logic [2:0] i, input logic [1:0] s);
        rst_n <= 1'b0;
        init_cfg <= i;
        sub_cfg <= s;
        cyc(2);
        #1 chk(16'(cur_src), 16'h0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
    endtask

    // full switch; the change lands on the tenth new-source tick, not the ninth
    task automatic switch_to(input logic [2:0] s, input logic [2:0] old);
        osc_wr(1'b1, 16'(s) << 8);
        osc_wr(1'b0, 16'h0003);
        src_rdy <= 1'b1;
        cyc(3);
        strobe(9, 0);
        #1 chk(16'(cur_src), 16'(old));
        chk(16'(busy), 16'h1);
        @(posedge clk_sys);
        strobe(1, 0);
        #1 chk(16'(cur_src), 16'(s));
        chk(16'(busy), 16'h0);
        @(posedge clk_sys);
        src_rdy <= 1'b0;
    endtask

    // instruction and cpu enables over n oscillator ticks
    task automatic count_ticks(input int n, input int ei, input int ec);
        i0 = n_instr;
        c0 = n_cpu;
        p0 = n_per;
        strobe(n, 1);
        cyc(2);
        chk(16'(n_instr - i0), 16'(ei));
        chk(16'(n_per - p0), 16'(ei));
        chk(16'(n_cpu - c0), 16'(ec));
    endtask

    initial begin
        // every initial source code, with the submode cycling 0, 1, 2 by code
        for (int c = 0; c < 8; c++) begin
            do_reset(3'(c), 2'(c % 3));
            #1 chk(16'(cur_src), 16'(c));
            chk(16'(req_src), 16'(c));
            chk(16'(pri_act), 16'(c == 2 || c == 3));
            chk(16'(pri_mode), (c == 2 || c == 3) ? 16'(c % 3) : 16'h0);
            @(posedge clk_sys);
        end
        // erased configuration, standard crystal submode for later
        do_reset(3'h7, 2'h1);
        rd_chk(4'h0, 16'h7700);
        rd_chk(4'h2, 16'h3040);
        rd_chk(4'h4, 16'h0000);
        rd_chk(4'h8, 16'h0000);
        #1 chk({pre_ratio, post_ratio, frc_ratio[5:0]}, {6'h02, 4'h4, 6'h01});
        @(posedge clk_sys);
        count_ticks(16, 8, 8);
        wr_reg(4'h2, 16'h1800);
        count_ticks(16, 8, 4);
        // divisor fields at their top codes except doze, which is zero; bit 5 stays zero
        wr_reg(4'h2, 16'h8fff);
        rd_chk(4'h2, 16'h8fdf);
        #1 chk({1'b0, pre_ratio, frc_ratio}, {1'b0, 6'h21, 9'h100});
        chk(16'(post_ratio), 16'h8);
        @(posedge clk_sys);
        wr_reg(4'h2, 16'h8f9f);
        rd_chk(4'h2, 16'h8fdf);
        strobe(1, 3);
        rd_chk(4'h2, 16'h87df);
        wr_reg(4'h2, 16'h0fdf);
        strobe(1, 3);
        rd_chk(4'h2, 16'h0fdf);
        for (int k = 0; k < 8; k++) begin
            wr_reg(4'h2, 16'(k) << 8);
            #1 chk(16'(frc_ratio), (k == 7) ? 16'h0100 : 16'(1 << k));
            @(posedge clk_sys);
        end
        #1 chk(16'(post_ratio), 16'h2);
        @(posedge clk_sys);
        // guarded writes: unlocked once, a second write is ignored
        wr_reg(4'h0, 16'h0200);
        rd_chk(4'h0, 16'h7700);
        osc_wr(1'b1, 16'hfaff);
        rd_chk(4'h0, 16'h7200);
        wr_reg(4'h0, 16'h0100);
        rd_chk(4'h0, 16'h7200);
        switch_to(3'h2, 3'h7);
        #1 chk({pri_mode, 12'h0, pll_en, sec_en}, 16'h4001);
        @(posedge clk_sys);
        rd_chk(4'h0, 16'h2202);
        osc_wr(1'b0, 16'h0003);
        cyc(2);
        rd_chk(4'h0, 16'h2202);
        strobe(1, 2);
        rd_chk(4'h0, 16'h220a);
        osc_wr(1'b0, 16'h0002);
        rd_chk(4'h0, 16'h2202);
        // primary to primary with multiplier; lock bit follows the pll
        switch_to(3'h3, 3'h2);
        #1 chk(16'(pll_en), 16'h1);
        @(posedge clk_sys);
        rd_chk(4'h0, 16'h3322);
        // pll out of lock: status bit drops although the source keeps running
        pll_lock <= 1'b0;
        rd_chk(4'h0, 16'h3302);
        pll_lock <= 1'b1;
        // freeze with the config bit set blocks source and pll fields
        cfg0 <= 1'b1;
        osc_wr(1'b0, 16'h0082);
        osc_wr(1'b1, 16'h0000);
        rd_chk(4'h0, 16'h33a2);
        wr_reg(4'h2, 16'h001f);
        rd_chk(4'h2, 16'h0700);
        cfg0 <= 1'b0;
        osc_wr(1'b1, 16'h0000);
        rd_chk(4'h0, 16'h30a2);
        stop_test();
    end

    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #20000;
        fails++;
        stop_test();
    end
endmodule
